/* nvp_core_model.sv */
`timescale 1ns/100ps
module nvp_core_model
    import nvp_pkg::*;
(
    input wire logic clk,
    input wire logic core_stall,
    input wire logic [7:0] io_rdata,
    output logic io_wr,
    output logic io_rd,
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata
);
    initial begin
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 6'h00;
        io_wdata = 8'h00;
    end
    // one access, then hold off while stalled; released lines flip so stale values never pass
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        io_wr = w;
        io_rd = !w;
        io_addr = a;
        io_wdata = d;
        @(negedge clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = ~io_addr;
        io_wdata = ~io_wdata;
        do @(negedge clk); while (core_stall !== 1'b0);
    endtask
    task automatic put(input logic [8:0] a, input logic [7:0] d);
        acc(1'b1, NVP_OFS_ADDR_HI, {7'h00, a[8]});
        acc(1'b1, NVP_OFS_ADDR_LO, a[7:0]);
        acc(1'b1, NVP_OFS_DATA, d);
        acc(1'b1, NVP_OFS_CTRL, 8'h04);
        acc(1'b1, NVP_OFS_CTRL, 8'h02);
    endtask
    task automatic get(input logic [8:0] a, output logic [7:0] d);
        acc(1'b1, NVP_OFS_ADDR_HI, {7'h00, a[8]});
        acc(1'b1, NVP_OFS_ADDR_LO, a[7:0]);
        acc(1'b1, NVP_OFS_CTRL, 8'h01);
        acc(1'b0, NVP_OFS_DATA, 8'h00);
        d = io_rdata;
    endtask
endmodule

/* nvp_pkg.sv */
package nvp_pkg;
    localparam int NVP_DEPTH = 512;
    localparam int NVP_AW = 9;
    localparam int NVP_DW = 8;
    localparam int NVP_IOAW = 6;
    // i/o register offsets
    localparam logic [5:0] NVP_OFS_CTRL = 6'h1C;
    localparam logic [5:0] NVP_OFS_DATA = 6'h1D;
    localparam logic [5:0] NVP_OFS_ADDR_LO = 6'h1E;
    localparam logic [5:0] NVP_OFS_ADDR_HI = 6'h1F;
    // control and address-high register fields
    localparam int NVP_BIT_READ = 0;
    localparam int NVP_BIT_STROBE = 1;
    localparam int NVP_BIT_ARM = 2;
    localparam int NVP_BIT_ADDR_HI = 0;
    // timing
    localparam int NVP_ARM_CYCLES = 4;
    localparam int NVP_READ_STALL = 4;
    localparam int NVP_WRITE_STALL = 2;
    localparam int NVP_OSC_HZ = 1000000;
    localparam int NVP_CLK_HZ = 100000000;
    localparam int NVP_OSC_DIV = NVP_CLK_HZ / NVP_OSC_HZ;
    localparam int NVP_WRITE_OSC_CYCLES = 8448;
endpackage

/* nvp_port.sv */
`timescale 1ns/100ps
// Contract
// - 512 separately addressable nonvolatile bytes
// - registers reached through core i/o space
// - read stalls core four cycles
// - write start stalls core two cycles
// - self-timed write, completion visible to software
// - address bits 8..0 writable, upper read zero
// - addresses 0..511 map linearly to bytes
// - address undefined after reset, software loads
// - write stores data byte at address
// - read loads data byte from address
// - arm clears after four cycles; gates strobe
// - strobe bit stays set until write done
// - write lasts 8448 one-megahertz oscillator ticks
// - busy refuses reads and address writes
module nvp_port
    import nvp_pkg::*;
#(
    parameter int OSC_DIV = NVP_OSC_DIV,
    parameter int WRITE_TICKS = NVP_WRITE_OSC_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [nvp_pkg::NVP_IOAW-1:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic core_stall,
    output logic write_busy
);
    import nvp_pkg::*;

    localparam int DW_BITS = $clog2(OSC_DIV + 1);
    localparam int TW_BITS = $clog2(WRITE_TICKS + 1);
    localparam int BC_BITS = TW_BITS + DW_BITS;

    logic [NVP_AW-1:0] nv_address_field;
    logic [7:0] nv_data_byte;
    logic write_arm_bit;
    logic [2:0] arm_cnt;
    logic write_strobe_bit;
    logic [DW_BITS-1:0] div_cnt;
    logic osc_tick;
    logic [TW_BITS-1:0] wr_cnt;
    logic [BC_BITS-1:0] busy_cyc;
    logic [2:0] stall_cnt;
    logic commit;
    logic [7:0] store_q;

    function automatic logic ctrl_hit(input logic [NVP_IOAW-1:0] a, input int b,
                                      input logic [7:0] d);
        ctrl_hit = (a == NVP_OFS_CTRL) && d[b];
    endfunction

    // read trigger bit always reads back as zero
    function automatic logic [7:0] ctrl_view(input logic arm, input logic busy);
        ctrl_view = 8'h00;
        ctrl_view[NVP_BIT_ARM] = arm;
        ctrl_view[NVP_BIT_STROBE] = busy;
    endfunction

    wire arm_req = io_wr && ctrl_hit(io_addr, NVP_BIT_ARM, io_wdata) &&
                   !io_wdata[NVP_BIT_STROBE];
    // strobe honoured only while armed and idle
    wire start_wr = io_wr && ctrl_hit(io_addr, NVP_BIT_STROBE, io_wdata) &&
                    write_arm_bit && !write_strobe_bit;
    wire start_rd = io_wr && ctrl_hit(io_addr, NVP_BIT_READ, io_wdata) &&
                    !write_strobe_bit;
    wire done_wr = write_strobe_bit && osc_tick &&
                   (wr_cnt == TW_BITS'(WRITE_TICKS - 1));

    // address: no reset value, software must load it
    always_ff @(posedge clk) begin
        if (io_wr && !write_strobe_bit) begin
            if (io_addr == NVP_OFS_ADDR_LO) begin
                nv_address_field[7:0] <= io_wdata;
            end else if (io_addr == NVP_OFS_ADDR_HI) begin
                nv_address_field[8] <= io_wdata[NVP_BIT_ADDR_HI];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nv_data_byte <= 8'h00;
        end else if (start_rd) begin
            nv_data_byte <= store_q;
        end else if (io_wr && io_addr == NVP_OFS_DATA) begin
            nv_data_byte <= io_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            write_arm_bit <= 1'b0;
            arm_cnt <= 3'h0;
        end else if (arm_req) begin
            write_arm_bit <= 1'b1;
            arm_cnt <= 3'(NVP_ARM_CYCLES - 1);
        end else if (write_arm_bit) begin
            if (arm_cnt == 3'h0) begin
                write_arm_bit <= 1'b0;
            end else begin
                arm_cnt <= arm_cnt - 3'h1;
            end
        end
    end

    // 1 mhz enable derived from core clock stands in for the oscillator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= '0;
        end else if (div_cnt == DW_BITS'(OSC_DIV - 1)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DW_BITS'(1);
        end
    end
    assign osc_tick = (div_cnt == DW_BITS'(OSC_DIV - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            write_strobe_bit <= 1'b0;
            wr_cnt <= '0;
        end else if (start_wr) begin
            write_strobe_bit <= 1'b1;
            wr_cnt <= '0;
        end else if (done_wr) begin
            write_strobe_bit <= 1'b0;
        end else if (write_strobe_bit && osc_tick) begin
            wr_cnt <= wr_cnt + TW_BITS'(1);
        end
    end

    // core-clock length of each write, kept apart from the tick counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cyc <= '0;
        end else if (start_wr) begin
            busy_cyc <= '0;
        end else if (write_strobe_bit) begin
            busy_cyc <= busy_cyc + BC_BITS'(1);
        end
    end

    // data committed at strobe; address is then frozen by busy, data register stays writable
    assign commit = start_wr;

    nvp_store u_store (
        .clk(clk),
        .wr_en(commit),
        .addr(nv_address_field),
        .wdata(nv_data_byte),
        .rdata(store_q)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stall_cnt <= 3'h0;
        end else if (start_rd) begin
            stall_cnt <= 3'(NVP_READ_STALL);
        end else if (start_wr) begin
            stall_cnt <= 3'(NVP_WRITE_STALL);
        end else if (stall_cnt != 3'h0) begin
            stall_cnt <= stall_cnt - 3'h1;
        end
    end
    assign core_stall = (stall_cnt != 3'h0);
    assign write_busy = write_strobe_bit;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            unique case (io_addr)
                NVP_OFS_CTRL: io_rdata <= ctrl_view(write_arm_bit, write_strobe_bit);
                NVP_OFS_DATA: io_rdata <= nv_data_byte;
                NVP_OFS_ADDR_LO: io_rdata <= nv_address_field[7:0];
                NVP_OFS_ADDR_HI: io_rdata <= {7'h00, nv_address_field[8]};
                default: io_rdata <= 8'h00;
            endcase
        end
    end

    a_read_stall: assert property (@(posedge clk) disable iff (!arst_n)
        start_rd |=> core_stall [*4] ##1 !core_stall)
        else $error("read stall not four cycles");
    a_write_stall: assert property (@(posedge clk) disable iff (!arst_n)
        start_wr |=> core_stall [*2] ##1 !core_stall)
        else $error("write stall not two cycles");
    a_arm_timeout: assert property (@(posedge clk) disable iff (!arst_n)
        arm_req |=> write_arm_bit [*4] ##1 !write_arm_bit)
        else $error("arm bit timeout wrong");
    a_no_unarmed: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(write_strobe_bit) |-> $past(write_arm_bit))
        else $error("write began unarmed");
    a_busy_len: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(write_strobe_bit) |-> int'(busy_cyc) > (WRITE_TICKS - 1) * OSC_DIV &&
            int'(busy_cyc) <= WRITE_TICKS * OSC_DIV)
        else $error("write length wrong");
    a_addr_frozen: assert property (@(posedge clk) disable iff (!arst_n)
        write_strobe_bit && $past(write_strobe_bit) |-> $stable(nv_address_field))
        else $error("address changed while busy");
    a_no_read_busy: assert property (@(posedge clk) disable iff (!arst_n)
        write_strobe_bit && io_wr && ctrl_hit(io_addr, NVP_BIT_READ, io_wdata) |=>
            $stable(nv_data_byte) && stall_cnt != 3'(NVP_READ_STALL))
        else $error("read accepted while busy");
    a_no_restart: assert property (@(posedge clk) disable iff (!arst_n)
        write_strobe_bit && !done_wr |=> write_strobe_bit && wr_cnt >= $past(wr_cnt))
        else $error("busy write restarted");
    a_read_data: assert property (@(posedge clk) disable iff (!arst_n)
        start_rd |=> nv_data_byte == $past(store_q))
        else $error("read data not loaded");
    a_addr_hi_zero: assert property (@(posedge clk) disable iff (!arst_n)
        io_rd && io_addr == NVP_OFS_ADDR_HI |=> io_rdata[7:NVP_BIT_ADDR_HI + 1] == '0)
        else $error("reserved address bits not zero");
    a_strobe_view: assert property (@(posedge clk) disable iff (!arst_n)
        io_rd && io_addr == NVP_OFS_CTRL |=> io_rdata[NVP_BIT_STROBE] == $past(write_strobe_bit))
        else $error("busy bit not visible");
endmodule

/* nvp_store.sv */
`timescale 1ns/100ps
module nvp_store
    import nvp_pkg::*;
#(
    parameter int DEPTH = NVP_DEPTH,
    parameter int AW = NVP_AW,
    parameter int DW = NVP_DW
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];

    // nonvolatile cells: no reset, contents survive core reset
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule

/* test_nvp_port.sv */
`timescale 1ns/100ps
module test_nvp_port;
    import nvp_pkg::*;
    // short write time keeps the run small
    localparam int DIV = 2;
    localparam int TICKS = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic io_wr, io_rd, core_stall, write_busy;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, got;
    int n_mismatch = 0;
    int n_tests = 0;
    int stall_len = 0;
    int busy_len = 0;
    logic [8:0] r_addr [5] = '{9'h000, 9'h1FF, 9'h0FF, 9'h100, 9'h0AA};
    logic [7:0] r_data [5] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h01};
    nvp_port #(.OSC_DIV(DIV), .WRITE_TICKS(TICKS)) i_nvp_port (.clk(clk), .arst_n(arst_n),
        .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .core_stall(core_stall), .write_busy(write_busy));
    nvp_core_model i_nvp_core_model (.clk(clk), .core_stall(core_stall), .io_rdata(io_rdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (core_stall === 1'b1) stall_len++;
        if (write_busy === 1'b1) busy_len++;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // bounded poll of the busy flag, then duration within one divider phase
    task automatic wait_done();
        for (int k = 0; k < 200 && write_busy !== 1'b0; k++) @(negedge clk);
        chk("busy end", 16'h0, {15'h0, write_busy});
        chk("busy len", 16'h1,
            {15'h0, busy_len > (TICKS - 1) * DIV && busy_len <= TICKS * DIV});
    endtask
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (2) @(negedge clk);
        chk("reset outs", 16'h0, {6'h0, io_rdata, core_stall, write_busy});
        arst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            stall_len = 0;
            busy_len = 0;
            i_nvp_core_model.put(r_addr[i], r_data[i]);
            chk("write stall", 16'd2, 16'(stall_len));
            i_nvp_core_model.acc(1'b0, NVP_OFS_CTRL, 8'h00);
            chk("strobe bit", 16'h1, {15'h0, io_rdata[NVP_BIT_STROBE]});
            wait_done();
        end
        for (int i = 0; i < 5; i++) begin
            stall_len = 0;
            i_nvp_core_model.get(r_addr[i], got);
            chk("read data", {8'h0, r_data[i]}, {8'h0, got});
            chk("read stall", 16'd4, 16'(stall_len));
        end
        $display("done: table rows");
        // strobe without arm, arm with strobe, stale arm: none may write
        i_nvp_core_model.acc(1'b1, NVP_OFS_ADDR_HI, 8'h00);
        i_nvp_core_model.acc(1'b1, NVP_OFS_ADDR_LO, 8'h00);
        i_nvp_core_model.acc(1'b1, NVP_OFS_DATA, 8'h77);
        i_nvp_core_model.acc(1'b1, NVP_OFS_CTRL, 8'h02);
        i_nvp_core_model.acc(1'b1, NVP_OFS_CTRL, 8'h06);
        i_nvp_core_model.acc(1'b1, NVP_OFS_CTRL, 8'h04);
        repeat (5) @(negedge clk);
        i_nvp_core_model.acc(1'b1, NVP_OFS_CTRL, 8'h02);
        chk("no busy", 16'h0, {15'h0, write_busy});
        i_nvp_core_model.get(9'h000, got);
        chk("unarmed data", 16'h005A, {8'h0, got});
        $display("done: arm gating");
        stall_len = 0;
        busy_len = 0;
        i_nvp_core_model.put(9'h010, 8'h99);
        i_nvp_core_model.acc(1'b1, NVP_OFS_ADDR_LO, 8'h20);
        i_nvp_core_model.acc(1'b1, NVP_OFS_CTRL, 8'h01);
        i_nvp_core_model.acc(1'b1, NVP_OFS_CTRL, 8'h04);
        i_nvp_core_model.acc(1'b1, NVP_OFS_CTRL, 8'h02);
        chk("busy stall", 16'd2, 16'(stall_len));
        wait_done();
        i_nvp_core_model.acc(1'b0, NVP_OFS_ADDR_LO, 8'h00);
        chk("frozen addr", 16'h0010, {8'h0, io_rdata});
        i_nvp_core_model.get(9'h010, got);
        chk("busy write", 16'h0099, {8'h0, got});
        $display("done: busy refusals");
        i_nvp_core_model.acc(1'b1, NVP_OFS_ADDR_HI, 8'hFF);
        i_nvp_core_model.acc(1'b0, NVP_OFS_ADDR_HI, 8'h00);
        chk("addr high", 16'h0001, {8'h0, io_rdata});
        $display("done: reserved bits");
        // mid-run reset: outputs clear, stored bytes survive
        arst_n = 1'b0;
        @(negedge clk);
        chk("mid reset", 16'h0, {6'h0, io_rdata, core_stall, write_busy});
        arst_n = 1'b1;
        i_nvp_core_model.get(9'h1FF, got);
        chk("kept data", 16'h00A5, {8'h0, got});
        $display("done: reset");
        finish_test();
    end
endmodule
